// *** core/rvc_pkg.sv ***
// rvc_pkg: constants and types shared by the restore/transfer value command block
// assumes one clock domain; the tag engine answers on the same clock
package rvc_pkg;
  // host register port byte addresses
  localparam logic [4:0] ADDR_CMD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h01;
  localparam logic [4:0] ADDR_ARG0 = 5'h08;
  localparam logic [4:0] ADDR_KEY_IDX = 5'h10;
  localparam logic [4:0] ADDR_KEY_B0 = 5'h11;
  localparam logic [4:0] ADDR_KEY_COMMIT = 5'h17;
  // command codes
  localparam logic [7:0] CMD_RESTORE = 8'h0e;
  localparam logic [7:0] CMD_TRANSFER = 8'h0f;
  // argument offsets
  localparam int ARG_BLK = 'h00;
  localparam int ARG_KSEL = 'h01;
  localparam int ARG_KEY = 'h02;
  localparam int ARG_KEY_LEN = 'h06;
  localparam int ARG_NUM = 8;
  // key selector fields
  localparam int KSEL_B_BIT = 7;
  localparam int KSEL_EXPL_BIT = 6;
  localparam int KSEL_IDX_W = 6;
  localparam int KEY_SLOTS = 40;
  localparam int KEY_W = 48;
  // result codes
  localparam logic [3:0] RES_OK = 4'h0;
  localparam logic [3:0] RES_AUTH_ERR = 4'h1;
  localparam logic [3:0] RES_FMT_ERR = 4'h2;
  localparam logic [3:0] RES_BAD_CMD = 4'h3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_RES = 4'h0;

  typedef enum logic [1:0] {
    TOP_AUTH,
    TOP_READ,
    TOP_RESTORE,
    TOP_TRANSFER
  } rvc_tag_op_t;

  typedef struct packed {
    logic req;
    rvc_tag_op_t op;
    logic [7:0] blk;
    logic [KEY_W-1:0] key;
    logic key_b;
    logic [31:0] value;
  } rvc_tag_req_t;

  typedef struct packed {
    logic ack;
    logic ok;
    logic [127:0] data;
  } rvc_tag_rsp_t;
endpackage : rvc_pkg

// *** core/rvc_keystore.sv ***
// rvc_keystore: stored authentication key slots, one write port, registered read
// assumes writes come from the command block on the same clock
`timescale 1ns/1ps
`default_nettype none
module rvc_keystore (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [5:0] widx_i,
  input wire logic [47:0] wkey_i,
  input wire logic [5:0] ridx_i,
  output logic [47:0] rkey_o,
  output logic rvalid_o
);
  logic [47:0] slot [rvc_pkg::KEY_SLOTS];

  // no reset on the array: keys are loaded by software before use
  always_ff @(posedge mclk_i)
  begin
    if (we_i && (widx_i < 6'(rvc_pkg::KEY_SLOTS)))
    begin
      slot[widx_i] <= wkey_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rkey_o <= '0;
      rvalid_o <= 1'b0;
    end
    else if (ridx_i < 6'(rvc_pkg::KEY_SLOTS))
    begin
      rkey_o <= slot[ridx_i];
      rvalid_o <= 1'b1;
    end
    else
    begin
      rkey_o <= '0;
      rvalid_o <= 1'b0;
    end
  end
endmodule // rvc_keystore
`default_nettype wire

// *** core/rvc_valchk.sv ***
// rvc_valchk: checks that a 16-byte tag block holds a well formed value block
// assumes the block image arrives with byte 0 in the low bits
`timescale 1ns/1ps
`default_nettype none
module rvc_valchk (
  input wire logic [127:0] blk_i,
  output logic ok_o,
  output logic [31:0] value_o
);
  logic [31:0] v0;
  logic [31:0] v1;
  logic [31:0] v2;
  logic [7:0] a0;
  logic [7:0] a1;
  logic [7:0] a2;
  logic [7:0] a3;

  always_comb
  begin
    v0 = blk_i[31:0];
    v1 = blk_i[63:32];
    v2 = blk_i[95:64];
    a0 = blk_i[103:96];
    a1 = blk_i[111:104];
    a2 = blk_i[119:112];
    a3 = blk_i[127:120];
    // value, inverted value, value; address byte with one plain and two inverted copies
    ok_o = (v1 == ~v0) && (v2 == v0) && (a1 == ~a0) && (a2 == a0) && (a3 == ~a0);
    value_o = v0;
  end
endmodule // rvc_valchk
`default_nettype wire

// *** core/rvc_cmd.sv ***
// rvc_cmd: restore/transfer value command decoder and sequencer
// assumes a host on a plain register port and a tag engine on the same clock
`timescale 1ns/1ps
`default_nettype none
module rvc_cmd (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic busy_o,
  output logic done_o,
  output logic [3:0] result_o,
  output rvc_pkg::rvc_tag_req_t tag_req_o,
  input wire rvc_pkg::rvc_tag_rsp_t tag_rsp_i
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_KEY,
    ST_AUTH,
    ST_READ,
    ST_WRITE
  } rvc_state_t;

  typedef struct packed {
    rvc_state_t st;
    logic [7:0] cmd;
    logic [rvc_pkg::ARG_NUM-1:0][7:0] arg;
    logic [5:0] kidx;
    logic [5:0][7:0] kbuf;
    logic kwe;
    logic [7:0] rdata;
    logic busy;
    logic done;
    logic [3:0] result;
    rvc_pkg::rvc_tag_req_t tag;
  } rvc_regs_t;

  rvc_regs_t r;
  rvc_regs_t next_r;
  logic [47:0] store_key;
  logic store_valid;
  logic fmt_ok;
  logic [31:0] fmt_value;
  logic [7:0] ksel;
  logic [47:0] expl_key;

  // argument byte offsets mapped onto the register window
  function automatic logic is_arg(input logic [4:0] a);
    return (a >= rvc_pkg::ADDR_ARG0) && (a < rvc_pkg::ADDR_ARG0 + 5'(rvc_pkg::ARG_NUM));
  endfunction

  function automatic logic is_kbyte(input logic [4:0] a);
    return (a >= rvc_pkg::ADDR_KEY_B0) && (a < rvc_pkg::ADDR_KEY_B0 + 5'd6);
  endfunction

  assign ksel = r.arg[rvc_pkg::ARG_KSEL];
  // explicit key: lowest argument offset is the least significant byte
  assign expl_key = {r.arg[7], r.arg[6], r.arg[5], r.arg[4], r.arg[3], r.arg[2]};

  rvc_keystore u_keys (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .we_i(r.kwe),
    .widx_i(r.kidx),
    .wkey_i(r.kbuf),
    .ridx_i(ksel[rvc_pkg::KSEL_IDX_W-1:0]),
    .rkey_o(store_key),
    .rvalid_o(store_valid)
  );

  rvc_valchk u_chk (
    .blk_i(tag_rsp_i.data),
    .ok_o(fmt_ok),
    .value_o(fmt_value)
  );

  always_comb
  begin
    next_r = r;
    next_r.kwe = 1'b0;
    next_r.rdata = rvc_pkg::RST_BYTE;
    // register reads, answered in the next cycle
    if (rd_i)
    begin
      if (addr_i == rvc_pkg::ADDR_CMD)
      begin
        next_r.rdata = r.cmd;
      end
      else if (addr_i == rvc_pkg::ADDR_STATUS)
      begin
        next_r.rdata = {r.busy, r.done, 2'b00, r.result};
      end
      else if (is_arg(addr_i))
      begin
        next_r.rdata = r.arg[3'(addr_i - rvc_pkg::ADDR_ARG0)];
      end
      else if (addr_i == rvc_pkg::ADDR_KEY_IDX)
      begin
        next_r.rdata = {2'b00, r.kidx};
      end
    end
    // arguments and key loading are frozen while a command runs
    if (wr_i && !r.busy)
    begin
      if (is_arg(addr_i))
      begin
        next_r.arg[3'(addr_i - rvc_pkg::ADDR_ARG0)] = wdata_i;
      end
      else if (addr_i == rvc_pkg::ADDR_KEY_IDX)
      begin
        next_r.kidx = wdata_i[5:0];
      end
      else if (is_kbyte(addr_i))
      begin
        next_r.kbuf[3'(addr_i - rvc_pkg::ADDR_KEY_B0)] = wdata_i;
      end
      else if (addr_i == rvc_pkg::ADDR_KEY_COMMIT)
      begin
        next_r.kwe = 1'b1;
      end
    end
    // tag request holds until the engine acknowledges it
    if (tag_rsp_i.ack)
    begin
      next_r.tag.req = 1'b0;
    end
    case (r.st)
      ST_IDLE:
      begin
        if (wr_i && (addr_i == rvc_pkg::ADDR_CMD))
        begin
          next_r.cmd = wdata_i;
          next_r.done = 1'b0;
          if ((wdata_i == rvc_pkg::CMD_RESTORE) || (wdata_i == rvc_pkg::CMD_TRANSFER))
          begin
            next_r.st = ST_KEY;
            next_r.busy = 1'b1;
          end
          else
          begin
            next_r.done = 1'b1;
            next_r.result = rvc_pkg::RES_BAD_CMD;
          end
        end
      end
      ST_KEY:
      begin
        next_r.tag.blk = r.arg[rvc_pkg::ARG_BLK];
        next_r.tag.key_b = ksel[rvc_pkg::KSEL_B_BIT];
        next_r.tag.op = rvc_pkg::TOP_AUTH;
        if (ksel[rvc_pkg::KSEL_EXPL_BIT])
        begin
          next_r.tag.key = expl_key;
          next_r.tag.req = 1'b1;
          next_r.st = ST_AUTH;
        end
        else if (store_valid)
        begin
          next_r.tag.key = store_key;
          next_r.tag.req = 1'b1;
          next_r.st = ST_AUTH;
        end
        else
        begin
          // slot beyond 39 counts as a failed authentication
          next_r.st = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.result = rvc_pkg::RES_AUTH_ERR;
        end
      end
      ST_AUTH:
      begin
        if (tag_rsp_i.ack)
        begin
          if (!tag_rsp_i.ok)
          begin
            next_r.st = ST_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.result = rvc_pkg::RES_AUTH_ERR;
          end
          else if (r.cmd == rvc_pkg::CMD_RESTORE)
          begin
            next_r.tag.op = rvc_pkg::TOP_READ;
            next_r.tag.req = 1'b1;
            next_r.st = ST_READ;
          end
          else
          begin
            next_r.tag.op = rvc_pkg::TOP_TRANSFER;
            next_r.tag.req = 1'b1;
            next_r.st = ST_WRITE;
          end
        end
      end
      ST_READ:
      begin
        if (tag_rsp_i.ack)
        begin
          if (tag_rsp_i.ok && fmt_ok)
          begin
            // only the volatile register is loaded; no block is written
            next_r.tag.op = rvc_pkg::TOP_RESTORE;
            next_r.tag.value = fmt_value;
            next_r.tag.req = 1'b1;
            next_r.st = ST_WRITE;
          end
          else
          begin
            next_r.st = ST_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.result = rvc_pkg::RES_FMT_ERR;
          end
        end
      end
      ST_WRITE:
      begin
        if (tag_rsp_i.ack)
        begin
          next_r.st = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.result = tag_rsp_i.ok ? rvc_pkg::RES_OK : rvc_pkg::RES_AUTH_ERR;
        end
      end
      default:
      begin
        next_r.st = ST_IDLE;
        next_r.busy = 1'b0;
        next_r.tag.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.result <= rvc_pkg::RST_RES;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;
  assign busy_o = r.busy;
  assign done_o = r.done;
  assign result_o = r.result;
  assign tag_req_o = r.tag;

  sequence seq_restore_cmd;
    wr_i && (addr_i == rvc_pkg::ADDR_CMD) && (wdata_i == rvc_pkg::CMD_RESTORE) && !r.busy;
  endsequence

  sequence seq_read_bad;
    (r.st == ST_READ) && tag_rsp_i.ack && !(tag_rsp_i.ok && fmt_ok);
  endsequence

  sequence seq_auth_bad;
    (r.st == ST_AUTH) && tag_rsp_i.ack && !tag_rsp_i.ok;
  endsequence

  AST_CMD_START: assert property (@(posedge mclk_i) disable iff (rst_i)
    seq_restore_cmd |=> (busy_o && !done_o) ##1 ((r.st == ST_AUTH) || done_o))
    else $error("restore code did not start a run");

  AST_KEY_SIDE: assert property (@(posedge mclk_i) disable iff (rst_i)
    tag_req_o.req && (tag_req_o.op == rvc_pkg::TOP_AUTH) |-> tag_req_o.key_b == ksel[7])
    else $error("key side does not follow selector bit 7");

  AST_EXPL_KEY: assert property (@(posedge mclk_i) disable iff (rst_i)
    tag_req_o.req && (tag_req_o.op == rvc_pkg::TOP_AUTH) && ksel[6]
      |-> tag_req_o.key == {r.arg[7], r.arg[6], r.arg[5], r.arg[4], r.arg[3], r.arg[2]})
    else $error("explicit key not taken lsb first from arguments");

  AST_SLOT_RANGE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.st == ST_KEY) && !ksel[6] && (ksel[5:0] > 6'd39) |=> done_o && (result_o == 4'h1))
    else $error("slot above 39 not refused");

  AST_FMT_ERR: assert property (@(posedge mclk_i) disable iff (rst_i)
    seq_read_bad |=> !busy_o && (result_o == 4'h2) && !tag_req_o.req)
    else $error("bad value block not refused");

  AST_AUTH_ERR: assert property (@(posedge mclk_i) disable iff (rst_i)
    seq_auth_bad |=> (!tag_req_o.req) [*2] ##0 (result_o == 4'h1))
    else $error("failed auth still touched the tag");

  AST_RESTORE_ONLY: assert property (@(posedge mclk_i) disable iff (rst_i)
    tag_req_o.req && (r.cmd == rvc_pkg::CMD_RESTORE) |-> tag_req_o.op != rvc_pkg::TOP_TRANSFER)
    else $error("restore wrote back to a block");

  AST_RESTORE_VALUE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (r.st == ST_READ) && tag_rsp_i.ack && tag_rsp_i.ok && fmt_ok
      |=> tag_req_o.req && (tag_req_o.op == rvc_pkg::TOP_RESTORE)
        && (tag_req_o.value == $past(tag_rsp_i.data[31:0])))
    else $error("restored value differs from block value");

  AST_XFER: assert property (@(posedge mclk_i) disable iff (rst_i)
    tag_req_o.req && (tag_req_o.op == rvc_pkg::TOP_TRANSFER) |-> r.cmd == 8'h0f)
    else $error("transfer issued outside transfer command");
endmodule // rvc_cmd
`default_nettype wire

// *** sim/rvc_tag_model.sv ***
// rvc_tag_model: behavioural tag engine on the far side of the command block
// assumes one clock; one ack for each request, fast or slow as slow_i asks
`timescale 1ns/1ps
`default_nettype none
module rvc_tag_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire rvc_pkg::rvc_tag_req_t req_i,
  input wire logic [47:0] key_i,
  input wire logic key_b_i,
  input wire logic [127:0] img_i,
  input wire logic slow_i,
  output rvc_pkg::rvc_tag_rsp_t rsp_o,
  output logic [31:0] vol_o,
  output logic [31:0] xfer_o,
  output logic [7:0] blk_o
);
  logic [2:0] wait_cnt;
  always @(posedge mclk_i)
  begin
    // outside an ack, ok and data flip every cycle so stale values never look valid
    rsp_o.ack <= 1'b0;
    rsp_o.ok <= ~rsp_o.ok;
    rsp_o.data <= ~rsp_o.data;
    if (rst_i)
    begin
      wait_cnt <= 3'h0;
      rsp_o <= '0;
      vol_o <= 32'h0;
    end
    else if (wait_cnt != 3'h0)
      wait_cnt <= wait_cnt - 3'h1;
    else if (req_i.req)
    begin
      rsp_o.ack <= 1'b1;
      rsp_o.ok <= 1'b1;
      // skip the cycle after an ack: the old request may still show there
      wait_cnt <= slow_i ? 3'h5 : 3'h1;
      case (req_i.op)
        rvc_pkg::TOP_AUTH:
        begin
          rsp_o.ok <= (req_i.key === key_i) && (req_i.key_b === key_b_i);
        end
        rvc_pkg::TOP_READ:
        begin
          rsp_o.data <= img_i;
          blk_o <= req_i.blk;
        end
        rvc_pkg::TOP_RESTORE: vol_o <= req_i.value;
        default: xfer_o <= vol_o;
      endcase
    end
  end
endmodule // rvc_tag_model
`default_nettype wire

// *** sim/test_restore_value_command.sv ***
// test_restore_value_command: self-checking bench for rvc_cmd
// assumes rvc_tag_model as the tag engine and the bench as register host
`timescale 1ns/1ps
`default_nettype none
module test_restore_value_command;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic busy_o;
  logic done_o;
  logic [3:0] result_o;
  rvc_pkg::rvc_tag_req_t tag_req_o;
  rvc_pkg::rvc_tag_rsp_t tag_rsp_i;
  logic [47:0] key = 48'h0;
  logic key_b = 1'b0;
  logic [127:0] img = 128'h0;
  logic slow = 1'b0;
  logic [31:0] vol;
  logic [31:0] xfer;
  logic [7:0] blk;
  logic [7:0] d;
  logic [7:0] b;
  logic [5:0] slot;
  logic [31:0] v;
  logic [31:0] prev;
  int errors = 0;
  int n_checks = 0;

  always #2.5 mclk_i = ~mclk_i;

  rvc_cmd i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o), .done_o(done_o),
    .result_o(result_o), .tag_req_o(tag_req_o), .tag_rsp_i(tag_rsp_i));
  rvc_tag_model i_tag (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(tag_req_o), .key_i(key),
    .key_b_i(key_b), .img_i(img), .slow_i(slow), .rsp_o(tag_rsp_i), .vol_o(vol),
    .xfer_o(xfer), .blk_o(blk));

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= x;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] x);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    x = rdata_o;
  endtask

  // value block image, byte 0 in the low bits
  function automatic logic [127:0] mk_img(input logic [31:0] val, input logic [7:0] a);
    return {~a, a, ~a, a, val, ~val, val};
  endfunction

  task automatic load(input logic [5:0] idx, input logic [47:0] k);
    wr(rvc_pkg::ADDR_KEY_IDX, {2'b00, idx});
    for (int i = 0; i < 6; i++)
      wr(rvc_pkg::ADDR_KEY_B0 + 5'(i), k[8*i+:8]);
    wr(rvc_pkg::ADDR_KEY_COMMIT, 8'h00);
  endtask

  task automatic run(input logic [7:0] cmd, input logic [7:0] ba, input logic [7:0] ksel,
    input logic [47:0] k, input logic [3:0] exp);
    int n;
    wr(rvc_pkg::ADDR_ARG0, ba);
    wr(rvc_pkg::ADDR_ARG0 + 5'h01, ksel);
    for (int i = 0; i < 6; i++)
      wr(rvc_pkg::ADDR_ARG0 + 5'(2 + i), k[8*i+:8]);
    wr(rvc_pkg::ADDR_CMD, cmd);
    @(posedge mclk_i);
    for (n = 0; n < 300; n++)
    begin
      @(negedge mclk_i);
      if (done_o === 1'b1 && busy_o === 1'b0)
        break;
    end
    if (n == 300)
    begin
      errors++;
      finish_test();
    end
    check(32'(result_o), 32'(exp));
    rd(rvc_pkg::ADDR_STATUS, d);
    check(32'(d), {24'h0, 4'h4, exp});
  endtask

  initial
  begin
    v = $urandom(32'hef8d0b3d);
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(rvc_pkg::ADDR_STATUS, d);
    check(32'(d), 32'h0);
    rd(5'h1f, d);
    check(32'(d), 32'h0);
    for (int n = 0; n < 6; n++)
    begin
      slow = n[0];
      slot = (n == 0) ? 6'd39 : 6'($urandom_range(39, 0));
      key = {16'($urandom), 32'($urandom)};
      key_b = 1'($urandom);
      v = $urandom;
      b = 8'($urandom);
      img = mk_img(v, 8'($urandom));
      if (!n[1])
        load(slot, key);
      run(rvc_pkg::CMD_RESTORE, b, {key_b, n[1], slot}, n[1] ? key : ~key,
        rvc_pkg::RES_OK);
      check(vol, v);
      check(32'(blk), 32'(b));
    end
    prev = vol;
    run(rvc_pkg::CMD_RESTORE, b, {key_b, 7'h40}, ~key, rvc_pkg::RES_AUTH_ERR);
    run(rvc_pkg::CMD_RESTORE, b, {~key_b, 7'h40}, key, rvc_pkg::RES_AUTH_ERR);
    run(rvc_pkg::CMD_RESTORE, b, 8'd40, key, rvc_pkg::RES_AUTH_ERR);
    img[39:32] = ~img[39:32];
    run(rvc_pkg::CMD_RESTORE, b, {key_b, 7'h40}, key, rvc_pkg::RES_FMT_ERR);
    check(vol, prev);
    run(8'h0d, b, {key_b, 7'h40}, key, rvc_pkg::RES_BAD_CMD);
    rd(rvc_pkg::ADDR_CMD, d);
    check(32'(d), 32'h0000_000d);
    // persisting the restored value takes a separate transfer
    run(rvc_pkg::CMD_TRANSFER, b, {key_b, 7'h40}, key, rvc_pkg::RES_OK);
    check(xfer, prev);
    finish_test();
  end
endmodule // test_restore_value_command
`default_nettype wire
